// *** cies_pkg.sv ***
// Package: opcodes, flag layout, cycle counts and carriers for the execute subset
package cies_pkg;

  // Opcode constants
  localparam logic [7:0] OP_ADC_IMM  = 8'hA9;
  localparam logic [7:0] OP_ADC_DIR  = 8'hB9;
  localparam logic [7:0] OP_ADD_IMM  = 8'hAB;
  localparam logic [7:0] OP_ADD_DIR  = 8'hBB;
  localparam logic [7:0] OP_SPBUMP   = 8'hA7;
  localparam logic [7:0] OP_IXBUMP   = 8'hAF;
  localparam logic [7:0] OP_AND_IMM  = 8'hA4;
  localparam logic [7:0] OP_AND_DIR  = 8'hB4;
  localparam logic [7:0] OP_CMP_IMM  = 8'hA1;
  localparam logic [7:0] OP_CMP_DIR  = 8'hB1;
  localparam logic [7:0] OP_CPXL_IMM = 8'hA3;
  localparam logic [7:0] OP_CPXL_DIR = 8'hB3;
  localparam logic [7:0] OP_EOR_IMM  = 8'hA8;
  localparam logic [7:0] OP_EOR_DIR  = 8'hB8;
  localparam logic [7:0] OP_SHLA     = 8'h48;
  localparam logic [7:0] OP_SHLX     = 8'h58;
  localparam logic [7:0] OP_SHRA     = 8'h47;
  localparam logic [7:0] OP_SHRX     = 8'h57;
  localparam logic [7:0] OP_INVA     = 8'h43;
  localparam logic [7:0] OP_INVX     = 8'h53;
  localparam logic [7:0] OP_DECA     = 8'h4A;
  localparam logic [7:0] OP_DECX     = 8'h5A;
  localparam logic [7:0] OP_DBNZA    = 8'h4B;
  localparam logic [7:0] OP_DBNZX    = 8'h5B;
  localparam logic [7:0] OP_BCC      = 8'h24;
  localparam logic [7:0] OP_INDEX_PAIR_COMPARE_IMM = 8'h65;
  localparam logic [7:0] OP_INDEX_PAIR_COMPARE_EXT = 8'h3E;
  localparam logic [7:0] OP_DAA      = 8'h72;
  localparam logic [7:0] OP_DIV      = 8'h52;
  localparam logic [7:0] OP_PREFIX   = 8'h9E;

  // Condition flag bit positions
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_I = 3;
  localparam int FL_H = 4;
  localparam int FL_V = 7;

  // Reset values
  localparam logic [15:0] RST_PC    = 16'h0000;
  localparam logic [15:0] RST_SP    = 16'h00FF;
  localparam logic [7:0]  RST_FLAGS = 8'h68;

  // Instruction cycle figures
  localparam logic [3:0] CYC_DIV  = 4'h6;
  localparam logic [3:0] CYC_BCC  = 4'h3;
  localparam logic [3:0] CYC_BUMP = 4'h2;
  localparam logic [3:0] CYC_COUNT_DOWN_BRANCH = 4'h4;
  localparam logic [3:0] CYC_INDEX_PAIR_COMPARE = 4'h3;

  // CPU register file carrier
  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  idxHigh;
    logic [7:0]  idxLow;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0]  flags;
  } cies_regs_t;

  // Memory request carrier
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cies_mem_req_t;

endpackage : cies_pkg

// *** cies_core.sv ***
// Execute core for an 8-bit accumulator instruction subset
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none

module cies_core (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic [7:0]             memRdata,
  output cies_pkg::cies_mem_req_t     memReq,
  output cies_pkg::cies_regs_t        regs,
  output logic                        illegalOp
);
  // ---------------------------------------------------------------
  // State machine
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_FETCH = 3'b000,
    ST_OPER  = 3'b001,
    ST_OPER2 = 3'b011,
    ST_EXEC  = 3'b010,
    ST_WAIT  = 3'b110
  } cies_state_t;
  cies_state_t state;
  logic [7:0]  opcode;
  logic [7:0]  opnd;
  logic [7:0]  opnd2;
  logic        prefixed;
  logic [3:0]  waitCnt;
  logic        firstRd;
  // Divide: 16 by 8, remainder in the high byte
  logic [15:0] dividend;
  logic [15:0] quot;
  logic [7:0]  remain;
  logic        divZero;
  function automatic logic [15:0] sext8(input logic [7:0] v);
    sext8 = {{8{v[7]}}, v};
  endfunction : sext8
  // 8-bit add or subtract with full flag set
  function automatic logic [12:0] alu8(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin, input logic sub);
    logic [8:0] r;
    logic [4:0] lo;
    logic [7:0] bb;
    logic       v;
    bb = sub ? ~b : b;
    r  = {1'b0, a} + {1'b0, bb} + {8'h00, cin ^ sub};
    lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin ^ sub};
    v  = (a[7] == bb[7]) && (r[7] != a[7]);
    // {V,H,N,Z,C,result}
    alu8 = {v, lo[4], r[7], (r[7:0] == 8'h00), r[8] ^ sub, r[7:0]};
  endfunction : alu8
  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  logic isDirect;
  logic needsOpnd;
  logic needsOpnd2;
  logic needsRead;
  assign isDirect   = (opcode[7:4] == 4'hB);
  assign needsOpnd  = (opcode[7:4] == 4'hA) || isDirect || (opcode == cies_pkg::OP_BCC)
                      || (opcode == cies_pkg::OP_DBNZA) || (opcode == cies_pkg::OP_DBNZX)
                      || (opcode == cies_pkg::OP_INDEX_PAIR_COMPARE_IMM) || (opcode == cies_pkg::OP_INDEX_PAIR_COMPARE_EXT);
  assign needsOpnd2 = (opcode == cies_pkg::OP_INDEX_PAIR_COMPARE_IMM) || (opcode == cies_pkg::OP_INDEX_PAIR_COMPARE_EXT);
  assign needsRead  = isDirect || (opcode == cies_pkg::OP_INDEX_PAIR_COMPARE_EXT);
  // Memory request: fetch at PC, or direct/extended operand read
  logic [15:0] ptrAddr;
  assign ptrAddr = isDirect ? {8'h00, opnd} : {opnd, opnd2};
  always_comb begin
    memReq       = '0;
    memReq.rd    = 1'b1;
    memReq.addr  = regs.pc;
    if (state == ST_EXEC && needsRead) begin
      memReq.addr = firstRd ? ptrAddr : ptrAddr + 16'h0001;
    end
  end
  assign dividend = {regs.idxHigh, regs.acc};
  assign divZero  = (regs.idxLow == 8'h00);
  assign quot     = divZero ? 16'hFFFF : dividend / {8'h00, regs.idxLow};
  assign remain   = divZero ? 8'h00 : 8'((dividend % {8'h00, regs.idxLow}));
  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  logic        execDone;
  logic [7:0]  memOp;
  logic [15:0] cmpWord;
  assign memOp = needsRead ? memRdata : opnd;
  // Fetch, operand gathering and timed waits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= ST_FETCH;
      opcode   <= 8'h00;
      opnd     <= 8'h00;
      opnd2    <= 8'h00;
      prefixed <= 1'b0;
      waitCnt  <= 4'h0;
      firstRd  <= 1'b1;
      cmpWord  <= 16'h0000;
    end else begin
      unique case (state)
        ST_FETCH: begin
          if (memRdata == cies_pkg::OP_PREFIX) begin
            prefixed <= 1'b1;
          end else begin
            opcode <= memRdata;
            state  <= ST_OPER;
          end
        end
        ST_OPER: begin
          if (needsOpnd) begin
            opnd  <= memRdata;
            state <= needsOpnd2 ? ST_OPER2 : ST_EXEC;
          end else begin
            state <= ST_EXEC;
          end
          firstRd <= 1'b1;
        end
        ST_OPER2: begin
          opnd2 <= memRdata;
          state <= ST_EXEC;
        end
        ST_EXEC: begin
          if (opcode == cies_pkg::OP_INDEX_PAIR_COMPARE_EXT && firstRd) begin
            cmpWord[15:8] <= memRdata;
            firstRd       <= 1'b0;
          end else if (waitCnt != 4'h0) begin
            state   <= ST_WAIT;
            waitCnt <= waitCnt - 4'h1;
          end else begin
            state    <= ST_FETCH;
            prefixed <= 1'b0;
          end
        end
        ST_WAIT: begin
          if (waitCnt == 4'h0) begin
            state    <= ST_FETCH;
            prefixed <= 1'b0;
          end else begin
            waitCnt <= waitCnt - 4'h1;
          end
        end
        default: state <= ST_FETCH;
      endcase
      // Pad divide and count-down branch to documented cycle counts, counted from fetch
      if (state == ST_OPER) begin
        unique case (opcode)
          cies_pkg::OP_DIV:   waitCnt <= cies_pkg::CYC_DIV - 4'h3;
          cies_pkg::OP_DBNZA,
          cies_pkg::OP_DBNZX: waitCnt <= cies_pkg::CYC_COUNT_DOWN_BRANCH - 4'h3;
          default:            waitCnt <= {3'b000, prefixed};
        endcase
      end
    end
  end

  assign execDone = (state == ST_EXEC)
                    && !(opcode == cies_pkg::OP_INDEX_PAIR_COMPARE_EXT && firstRd);
  // ---------------------------------------------------------------
  // Execute: register and flag updates
  // ---------------------------------------------------------------
  logic [12:0] aluR;
  logic [7:0]  tgt;
  logic        toX;
  logic [7:0]  dRes;
  logic [16:0] wDiff;
  logic [15:0] wOp;
  logic [7:0]  daaCor;
  logic [8:0]  daaSum;
  assign toX  = opcode[4];
  assign tgt  = toX ? regs.idxLow : regs.acc;
  assign dRes = tgt - 8'h01;
  assign wOp  = (opcode == cies_pkg::OP_INDEX_PAIR_COMPARE_IMM) ? {opnd, opnd2} : {cmpWord[15:8], memRdata};
  assign wDiff = {1'b0, regs.idxHigh, regs.idxLow} - {1'b0, wOp};
  assign daaCor = {(regs.flags[cies_pkg::FL_C] || regs.acc > 8'h99) ? 4'h6 : 4'h0,
                   (regs.flags[cies_pkg::FL_H] || regs.acc[3:0] > 4'h9) ? 4'h6 : 4'h0};
  assign daaSum = {1'b0, regs.acc} + {1'b0, daaCor};
  always_comb begin
    unique case (opcode)
      cies_pkg::OP_ADC_IMM, cies_pkg::OP_ADC_DIR:
        aluR = alu8(regs.acc, memOp, regs.flags[cies_pkg::FL_C], 1'b0);
      cies_pkg::OP_CMP_IMM, cies_pkg::OP_CMP_DIR:
        aluR = alu8(regs.acc, memOp, 1'b0, 1'b1);
      cies_pkg::OP_CPXL_IMM, cies_pkg::OP_CPXL_DIR:
        aluR = alu8(regs.idxLow, memOp, 1'b0, 1'b1);
      default:
        aluR = alu8(regs.acc, memOp, 1'b0, 1'b0);
    endcase
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regs.acc     <= 8'h00;
      regs.idxHigh <= 8'h00;
      regs.idxLow  <= 8'h00;
      regs.sp      <= cies_pkg::RST_SP;
      regs.pc      <= cies_pkg::RST_PC;
      regs.flags   <= cies_pkg::RST_FLAGS;
      illegalOp    <= 1'b0;
    end else begin
      illegalOp <= 1'b0;
      if (state == ST_FETCH || state == ST_OPER2 || (state == ST_OPER && needsOpnd)) begin
        regs.pc <= regs.pc + 16'h0001;
      end
      if (execDone) begin  // Results land at the execute edge; waits only pad
        unique case (opcode)
          cies_pkg::OP_ADC_IMM, cies_pkg::OP_ADC_DIR,
          cies_pkg::OP_ADD_IMM, cies_pkg::OP_ADD_DIR: begin
            regs.acc <= aluR[7:0];
            regs.flags[cies_pkg::FL_V] <= aluR[12];
            regs.flags[cies_pkg::FL_H] <= aluR[11];
            regs.flags[cies_pkg::FL_N] <= aluR[10];
            regs.flags[cies_pkg::FL_Z] <= aluR[9];
            regs.flags[cies_pkg::FL_C] <= aluR[8];
          end
          cies_pkg::OP_CMP_IMM, cies_pkg::OP_CMP_DIR,
          cies_pkg::OP_CPXL_IMM, cies_pkg::OP_CPXL_DIR: begin
            regs.flags[cies_pkg::FL_V] <= aluR[12];
            regs.flags[cies_pkg::FL_N] <= aluR[10];
            regs.flags[cies_pkg::FL_Z] <= aluR[9];
            regs.flags[cies_pkg::FL_C] <= aluR[8];
          end
          cies_pkg::OP_AND_IMM, cies_pkg::OP_AND_DIR,
          cies_pkg::OP_EOR_IMM, cies_pkg::OP_EOR_DIR: begin
            regs.acc <= opcode[3] ? (regs.acc ^ memOp) : (regs.acc & memOp);
            regs.flags[cies_pkg::FL_V] <= 1'b0;
            regs.flags[cies_pkg::FL_N] <= opcode[3] ? regs.acc[7] ^ memOp[7]
                                                    : regs.acc[7] & memOp[7];
            regs.flags[cies_pkg::FL_Z] <= opcode[3] ? ((regs.acc ^ memOp) == 8'h00)
                                                    : ((regs.acc & memOp) == 8'h00);
          end
          cies_pkg::OP_SPBUMP: regs.sp <= regs.sp + sext8(opnd);
          cies_pkg::OP_IXBUMP:
            {regs.idxHigh, regs.idxLow} <= {regs.idxHigh, regs.idxLow} + sext8(opnd);
          cies_pkg::OP_SHLA, cies_pkg::OP_SHLX: begin
            if (toX) regs.idxLow <= {tgt[6:0], 1'b0};
            else     regs.acc    <= {tgt[6:0], 1'b0};
            regs.flags[cies_pkg::FL_C] <= tgt[7];
            regs.flags[cies_pkg::FL_N] <= tgt[6];
            regs.flags[cies_pkg::FL_Z] <= (tgt[6:0] == 7'h00);
            regs.flags[cies_pkg::FL_V] <= tgt[7] ^ tgt[6];
          end
          cies_pkg::OP_SHRA, cies_pkg::OP_SHRX: begin
            if (toX) regs.idxLow <= {tgt[7], tgt[7:1]};
            else     regs.acc    <= {tgt[7], tgt[7:1]};
            regs.flags[cies_pkg::FL_C] <= tgt[0];
            regs.flags[cies_pkg::FL_N] <= tgt[7];
            regs.flags[cies_pkg::FL_Z] <= (tgt[7:1] == 7'h00) && !tgt[7];
            regs.flags[cies_pkg::FL_V] <= tgt[7] ^ tgt[0];
          end
          cies_pkg::OP_INVA, cies_pkg::OP_INVX: begin
            if (toX) regs.idxLow <= 8'hFF - tgt;
            else     regs.acc    <= 8'hFF - tgt;
            regs.flags[cies_pkg::FL_V] <= 1'b0;
            regs.flags[cies_pkg::FL_C] <= 1'b1;
            regs.flags[cies_pkg::FL_N] <= ~tgt[7];
            regs.flags[cies_pkg::FL_Z] <= (tgt == 8'hFF);
          end
          cies_pkg::OP_DECA, cies_pkg::OP_DECX: begin
            if (toX) regs.idxLow <= dRes;
            else     regs.acc    <= dRes;
            regs.flags[cies_pkg::FL_V] <= (tgt == 8'h80);
            regs.flags[cies_pkg::FL_N] <= dRes[7];
            regs.flags[cies_pkg::FL_Z] <= (dRes == 8'h00);
          end
          cies_pkg::OP_DBNZA, cies_pkg::OP_DBNZX: begin
            if (toX) regs.idxLow <= dRes;
            else     regs.acc    <= dRes;
            if (dRes != 8'h00) regs.pc <= regs.pc + sext8(opnd);
          end
          cies_pkg::OP_BCC: begin
            if (!regs.flags[cies_pkg::FL_C]) regs.pc <= regs.pc + sext8(opnd);
          end
          cies_pkg::OP_INDEX_PAIR_COMPARE_IMM, cies_pkg::OP_INDEX_PAIR_COMPARE_EXT: begin
            regs.flags[cies_pkg::FL_V] <= (regs.idxHigh[7] != wOp[15])
                                          && (wDiff[15] != regs.idxHigh[7]);
            regs.flags[cies_pkg::FL_N] <= wDiff[15];
            regs.flags[cies_pkg::FL_Z] <= (wDiff[15:0] == 16'h0000);
            regs.flags[cies_pkg::FL_C] <= wDiff[16];
          end
          cies_pkg::OP_DAA: begin
            regs.acc <= daaSum[7:0];
            regs.flags[cies_pkg::FL_C] <= regs.flags[cies_pkg::FL_C] || (daaCor[7:4] != 4'h0);
            regs.flags[cies_pkg::FL_N] <= daaSum[7];
            regs.flags[cies_pkg::FL_Z] <= (daaSum[7:0] == 8'h00);
          end
          cies_pkg::OP_DIV: begin
            if (!divZero && quot[15:8] == 8'h00) begin
              regs.acc     <= quot[7:0];
              regs.idxHigh <= remain;
            end
            regs.flags[cies_pkg::FL_C] <= divZero || (quot[15:8] != 8'h00);
            regs.flags[cies_pkg::FL_Z] <= (quot[7:0] == 8'h00);
          end
          default: illegalOp <= 1'b1;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic wasExecDone;
  logic [7:0] prevOp;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wasExecDone <= 1'b0;
      prevOp      <= 8'h00;
    end else begin
      wasExecDone <= execDone;
      prevOp      <= opcode;
    end
  end
  bump_flags_a: assert property (@(posedge clk) disable iff (sys_rst)
    wasExecDone && (prevOp == cies_pkg::OP_SPBUMP || prevOp == cies_pkg::OP_IXBUMP)
    |-> regs.flags == $past(regs.flags)) else $error("bump changed flags");
  inv_carry_a: assert property (@(posedge clk) disable iff (sys_rst)
    wasExecDone && (prevOp == cies_pkg::OP_INVA || prevOp == cies_pkg::OP_INVX)
    |-> regs.flags[cies_pkg::FL_C] && !regs.flags[cies_pkg::FL_V])
    else $error("complement flags wrong");
  cmp_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    wasExecDone && prevOp == cies_pkg::OP_CMP_IMM |-> regs.acc == $past(regs.acc))
    else $error("compare wrote accumulator");
  dec_carry_a: assert property (@(posedge clk) disable iff (sys_rst)
    wasExecDone && (prevOp == cies_pkg::OP_DECA || prevOp == cies_pkg::OP_DECX)
    |-> $stable(regs.flags[cies_pkg::FL_C])) else $error("decrement touched carry");
  count_down_branch_flags_a: assert property (@(posedge clk) disable iff (sys_rst)
    wasExecDone && (prevOp == cies_pkg::OP_DBNZX)
    |-> $stable(regs.flags) && $stable(regs.idxHigh)) else $error("count branch flags");
  and_v_a: assert property (@(posedge clk) disable iff (sys_rst)
    wasExecDone && prevOp == cies_pkg::OP_AND_IMM
    |-> !regs.flags[cies_pkg::FL_V] && $stable(regs.flags[cies_pkg::FL_C]))
    else $error("and flags wrong");
  div_time_a: assert property (@(posedge clk) disable iff (sys_rst)
    state == ST_FETCH && memRdata == cies_pkg::OP_DIV ##1 state == ST_OPER
    |-> ##4 state == ST_WAIT ##1 state == ST_FETCH) else $error("divide not six cycles");
  bcc_time_a: assert property (@(posedge clk) disable iff (sys_rst)
    state == ST_FETCH && memRdata == cies_pkg::OP_BCC && !prefixed
    |-> ##3 state == ST_FETCH) else $error("branch not three cycles");
  cov_div_c:  cover property (@(posedge clk) wasExecDone && prevOp == cies_pkg::OP_DIV);
  cov_bcc_c:  cover property (@(posedge clk) wasExecDone && prevOp == cies_pkg::OP_BCC);
  cov_index_pair_compare_c: cover property (@(posedge clk) wasExecDone && prevOp == cies_pkg::OP_INDEX_PAIR_COMPARE_EXT);
  cov_pfx_c:  cover property (@(posedge clk) prefixed && state == ST_WAIT);
endmodule : cies_core

`default_nettype wire

// *** cies_mem_model.sv ***
// Behavioural program and data memory standing on the core's bus
`timescale 1ns/100ps
`default_nettype none

module cies_mem_model (
  input  wire cies_pkg::cies_mem_req_t memReq,
  output logic [7:0]                  memRdata
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] store [0:65535];

  // Same-cycle read; an idle bus shows a pattern that follows the address
  always_comb begin
    if (memReq.rd === 1'b1) begin
      memRdata = store[memReq.addr];
    end else begin
      memRdata = ~memReq.addr[7:0];
    end
  end
endmodule : cies_mem_model
`default_nettype wire

// *** cpu_instruction_execute_subset_bench.sv ***
// Self-checking bench for the execute core, one or more checks per program
`timescale 1ns/100ps
`default_nettype none

module cpu_instruction_execute_subset_bench;
  logic                    clk;
  logic                    sysRst;
  logic [7:0]              memRdata;
  cies_pkg::cies_mem_req_t memReq;
  cies_pkg::cies_regs_t    regs;
  logic                    illegalOp;
  int                      n_errors;
  int                      compares;
  int                      nIllegal;

  cies_core dut (.clk(clk), .sys_rst(sysRst), .memRdata(memRdata), .memReq(memReq),
                 .regs(regs), .illegalOp(illegalOp));
  cies_mem_model memModel (.memReq(memReq), .memRdata(memRdata));

  // ----------------------------------------
  // Clock, pulse counter, helpers
  // ----------------------------------------
  initial clk = 1'b0;
  always #50 clk = ~clk;

  // Counts refused opcodes
  always @(posedge clk) begin
    if (illegalOp === 1'b1) nIllegal++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Loads a program at 0000, resets for 4 cycles, then lets it run
  task automatic run_prog(input logic [7:0] prog [$]);
    @(posedge clk);
    #1;
    sysRst = 1'b1;
    for (int i = 0; i < 256; i++) memModel.store[i] = 8'h00;
    foreach (prog[i]) memModel.store[i] = prog[i];
    memModel.store[16] = 8'h01;  // Direct-page operand
    repeat (4) @(posedge clk);
    #1;
    sysRst = 1'b0;
    nIllegal = 0;
    repeat (60) @(posedge clk);
    #1;
  endtask : run_prog

  task automatic print_verdict;
    $display("n_errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    @(posedge clk);
    #1;
    sysRst = 1'b1;
    @(posedge clk);
    #1;
    check(regs.pc, 16'h0000);
    check(regs.sp, 16'h00FF);
    check(regs.flags, 16'h0068);
    check({regs.acc, regs.idxLow}, 16'h0000);
    check(memReq.addr, 16'h0000);
    check({memReq.rd, memReq.wr}, 16'h0002);
    check(memReq.wdata, 16'h0000);
  endtask : t_reset

  task automatic t_refused;
    run_prog({8'h00});
    check(16'(nIllegal != 0), 16'h0001);
    check({regs.acc, regs.flags}, 16'h0068);
  endtask : t_refused

  task automatic t_add;
    run_prog({8'hAB, 8'h7F, 8'hB9, 8'h10});
    check({regs.acc, regs.flags}, 16'h80FC);
    run_prog({8'hAB, 8'h80, 8'hAB, 8'h80, 8'hA9, 8'h00});
    check({regs.acc, regs.flags}, 16'h0168);
    run_prog({8'hAB, 8'h80, 8'hAB, 8'h80, 8'hBB, 8'h10});
    check({regs.acc, regs.flags}, 16'h0168);
  endtask : t_add

  task automatic t_logic;
    run_prog({8'hAB, 8'h7F, 8'hAB, 8'h01, 8'hA4, 8'hC0});
    check({regs.acc, regs.flags}, 16'h807C);
    run_prog({8'hAB, 8'h7F, 8'hAB, 8'h01, 8'hA8, 8'h80});
    check({regs.acc, regs.flags}, 16'h007A);
  endtask : t_logic

  task automatic t_shift;
    run_prog({8'h53, 8'h5A, 8'h58, 8'h57, 8'hAB, 8'h81, 8'h48, 8'h47, 8'h43, 8'h4A});
    check({regs.idxHigh, regs.idxLow}, 16'h00FE);
    check({regs.acc, regs.flags}, 16'hFD6D);
  endtask : t_shift

  task automatic t_compare;
    run_prog({8'hAB, 8'h40, 8'hA1, 8'h41});
    check({regs.acc, regs.flags}, 16'h406D);
    run_prog({8'hA3, 8'h01});
    check({regs.idxLow, regs.flags}, 16'h006D);
    run_prog({8'h65, 8'h00, 8'h01});
    check({regs.idxHigh, regs.idxLow}, 16'h0000);
    check(regs.flags, 16'h006D);
    run_prog({8'h3E, 8'h00, 8'h20});
    check(regs.flags, 16'h006A);
  endtask : t_compare

  task automatic t_bump;
    run_prog({8'hAB, 8'h80, 8'hAB, 8'h80, 8'hA7, 8'hFE, 8'hAF, 8'h80});
    check(regs.sp, 16'h00FD);
    check({regs.idxHigh, regs.idxLow}, 16'hFF80);
    check(regs.flags, 16'h00EB);
  endtask : t_bump

  task automatic t_branch;
    run_prog({8'h24, 8'h04, 8'hAB, 8'h22, 8'h00, 8'h00, 8'hAB, 8'h11});
    check({regs.acc, regs.flags}, 16'h1168);
    run_prog({8'hAB, 8'h80, 8'hAB, 8'h80, 8'h24, 8'h02, 8'hAB, 8'h05, 8'hAB, 8'h10});
    check(regs.acc, 16'h0015);
    run_prog({8'hAB, 8'h02, 8'h5A, 8'h4B, 8'hFD});
    check({regs.acc, regs.idxLow}, 16'h00FE);
    check(regs.flags, 16'h006C);
  endtask : t_branch

  task automatic t_divide;
    run_prog({8'hAF, 8'h04, 8'hAB, 8'h0E, 8'h52, 8'h5B, 8'hFE});
    check({regs.acc, regs.idxHigh}, 16'h0302);
    check({regs.idxLow, regs.flags}, 16'h0068);
    run_prog({8'h52});
    check({regs.acc, 7'h00, regs.flags[cies_pkg::FL_C]}, 16'h0001);
  endtask : t_divide

  task automatic t_daa;
    run_prog({8'hAB, 8'h09, 8'hAB, 8'h08, 8'h72});
    check(regs.acc, 16'h0017);
    check({regs.flags[cies_pkg::FL_N], regs.flags[cies_pkg::FL_Z], regs.flags[cies_pkg::FL_C]},
          16'h0000);
  endtask : t_daa

  // Prefix byte is absorbed; the following opcode still runs
  task automatic t_prefix;
    run_prog({8'h9E, 8'hAB, 8'h05, 8'hAB, 8'h01});
    check(regs.acc, 16'h0006);
  endtask : t_prefix

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    sysRst = 1'b1;
    n_errors = 0;
    compares = 0;
    nIllegal = 0;
    repeat (4) @(posedge clk);
    t_reset();
    t_refused();
    t_add();
    t_logic();
    t_shift();
    t_compare();
    t_bump();
    t_branch();
    t_divide();
    t_daa();
    t_prefix();
    print_verdict();
  end

  // Cuts a hang short well past the expected run time
  initial begin
    #2000000;
    n_errors++;
    print_verdict();
  end
endmodule : cpu_instruction_execute_subset_bench
`default_nettype wire
